// ### verilog/pcm_power_clock_manager.sv
//Contract
//R1: reset bit restores all registers to defaults
//R2: reset bit clears itself when done
//R3: halt bit puts device to sleep
//R4: wake bit without halt samples periodically
//R5: thermo off bit disables temperature sensor
//R6: codes 0-3 select internal or gyro PLL
//R7: codes 4,5 select external reference PLLs
//R8: code 7 stops clock; 6 reserved
//R9: internal oscillator after power up
//R10: host should prefer gyro or external clock
//R11: low power with gyros off allowed
//R12: host SPI reset sequence with 100ms waits
//R13: wake rate field sets 1.25..40 Hz
//R14: host steps to enter accel-only mode
//R15: accel-only mode powers down all else
//R16: bits 5-3 put accel axes in standby
//R17: bits 2-0 put gyro axes in standby
//R18: standby of clock gyro forces internal oscillator
//R19: path register bits clear gyro/accel/temp paths
//R20: reserved bits ignore writes, read zero
`timescale 1ns/1ns
`include "pcm_defs.svh"
module pcm_power_clock_manager #(
   parameter int WAKE_US_0 = `PCM_WAKE_US_0,
   parameter int WAKE_US_1 = `PCM_WAKE_US_1,
   parameter int WAKE_US_2 = `PCM_WAKE_US_2,
   parameter int WAKE_US_3 = `PCM_WAKE_US_3
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   output logic device_reset_busy,
   output logic sleep_active,
   output logic [2:0] accel_axis_on,
   output logic [2:0] gyro_axis_on,
   output logic thermo_sensor_on,
   output logic accel_sample,
   output logic [2:0] clock_source,
   output logic timing_gen_hold,
   output logic gyro_path_clear,
   output logic accel_path_clear,
   output logic temp_path_clear
);
   // pin synchronisers: stage a feeds stage b only
   logic [2:0] sync_a_r;
   logic [2:0] sync_b_r;
   logic sclk_prev_r;
   logic sclk_s, cs_n_s, sdi_s, sclk_rise, sclk_fall;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_a_r <= 3'h7;
         sync_b_r <= 3'h7;
         sclk_prev_r <= 1'b1;
      end else begin
         sync_a_r <= {spi_sclk, spi_cs_n, spi_sdi};
         sync_b_r <= sync_a_r;
         sclk_prev_r <= sync_b_r[2];
      end
   end

   always_comb begin
      sclk_s = sync_b_r[2];
      cs_n_s = sync_b_r[1];
      sdi_s = sync_b_r[0];
      sclk_rise = sclk_s && !sclk_prev_r;
      sclk_fall = !sclk_s && sclk_prev_r;
   end

   pcm_pkg::pcm_pwr_type pwr_r, pwr_nxt;
   pcm_pkg::pcm_stby_type stby_r, stby_nxt;
   logic [4:0] rst_cnt_r, rst_cnt_nxt;
   logic [2:0] bit_cnt_r, bit_cnt_nxt;
   logic data_ph_r, data_ph_nxt;
   logic rd_r, rd_nxt;
   logic [6:0] addr_r, addr_nxt;
   logic [7:0] shin_r, shin_nxt;
   logic [7:0] tx_r, tx_nxt;
   logic sdo_r, sdo_nxt, sdo_oe_r, sdo_oe_nxt;
   logic [2:0] clr_r, clr_nxt;
   logic [5:0] us_div_r, us_div_nxt;
   logic [19:0] wake_cnt_r, wake_cnt_nxt;
   logic sample_r, sample_nxt;
   // registered busy flag so the pin comes straight from a flop
   logic busy_r, busy_nxt;
   logic sleep_r, sleep_nxt, temp_on_r, temp_on_nxt, hold_r, hold_nxt;
   logic [2:0] a_on_r, a_on_nxt, g_on_r, g_on_nxt, src_r, src_nxt;
   pcm_pkg::pcm_mode_type mode;
   logic [7:0] byte_in, rd_data, rd_next;
   logic busy, us_tick;
   logic [19:0] wake_period;

   // read data for the current and the following address
   function automatic logic [7:0] reg_read(input logic [6:0] a,
         input pcm_pkg::pcm_pwr_type p, input pcm_pkg::pcm_stby_type s,
         input logic bsy);
      logic [7:0] v;
      v = 8'h00;
      if (a == `PCM_ADDR_PWR) begin
         v = p & `PCM_PWR_WMASK; // [R20]
         v[`PCM_BIT_DEVRST] = bsy; // [R2]
      end else if (a == `PCM_ADDR_STBY) begin
         v = s;
      end
      return v;
   endfunction : reg_read

   always_comb begin
      busy = (rst_cnt_r != 5'h00);
      byte_in = {shin_r[6:0], sdi_s};
      rd_data = reg_read(addr_r, pwr_r, stby_r, busy);
      rd_next = reg_read(addr_r + 7'h01, pwr_r, stby_r, busy);
      case (stby_r.wake_rate_select) // [R13]
         2'h0: wake_period = 20'(WAKE_US_0);
         2'h1: wake_period = 20'(WAKE_US_1);
         2'h2: wake_period = 20'(WAKE_US_2);
         default: wake_period = 20'(WAKE_US_3);
      endcase
      if (pwr_r.halt) begin
         mode = pcm_pkg::PCM_MODE_SLEEP; // [R3]
      end else if (pwr_r.cycle_wake) begin
         mode = pcm_pkg::PCM_MODE_CYCLE; // [R4]
      end else begin
         mode = pcm_pkg::PCM_MODE_RUN;
      end
      us_tick = (us_div_r == 6'(`PCM_US_CYC - 1));
   end

   // serial port, register writes and device reset
   always_comb begin
      pwr_nxt = pwr_r;
      stby_nxt = stby_r;
      rst_cnt_nxt = busy ? rst_cnt_r - 5'h01 : rst_cnt_r;
      bit_cnt_nxt = bit_cnt_r;
      data_ph_nxt = data_ph_r;
      rd_nxt = rd_r;
      addr_nxt = addr_r;
      shin_nxt = shin_r;
      tx_nxt = tx_r;
      sdo_nxt = sdo_r;
      sdo_oe_nxt = 1'b0;
      clr_nxt = 3'h0;
      if (cs_n_s) begin
         bit_cnt_nxt = 3'h0;
         data_ph_nxt = 1'b0;
      end else begin
         sdo_oe_nxt = data_ph_r && rd_r;
         if (sclk_rise) begin
            shin_nxt = byte_in;
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
               if (!data_ph_r) begin
                  rd_nxt = byte_in[`PCM_SPI_RD_BIT];
                  addr_nxt = byte_in[6:0];
                  data_ph_nxt = 1'b1;
                  tx_nxt = reg_read(byte_in[6:0], pwr_r, stby_r, busy);
                  sdo_nxt = tx_nxt[7];
               end else begin
                  // burst: next byte goes to the next address
                  addr_nxt = addr_r + 7'h01;
                  tx_nxt = rd_next;
                  sdo_nxt = rd_next[7];
                  // writes during an internal reset are dropped
                  if (!rd_r && !busy) begin
                     if (addr_r == `PCM_ADDR_PWR) begin
                        if (byte_in[`PCM_BIT_DEVRST]) begin
                           rst_cnt_nxt = 5'(`PCM_RST_CYC); // [R1]
                        end else begin
                           pwr_nxt = byte_in & `PCM_PWR_WMASK; // [R20]
                           // reserved code keeps the previous source
                           if (byte_in[2:0] == `PCM_CLK_RSV) begin // [R8]
                              pwr_nxt.timing_source_select = pwr_r.timing_source_select;
                           end
                        end
                     end else if (addr_r == `PCM_ADDR_STBY) begin
                        stby_nxt = byte_in; // [R16] [R17]
                     end else if (addr_r == `PCM_ADDR_PATH) begin
                        clr_nxt = byte_in[2:0]; // [R19]
                     end
                  end
               end
            end
         end
         if (sclk_fall && data_ph_r && bit_cnt_r != 3'h0) begin
            tx_nxt = {tx_r[6:0], 1'b0};
            sdo_nxt = tx_r[6];
         end
      end
      if (busy) begin
         pwr_nxt = `PCM_PWR_RST; // [R1] [R9]
         stby_nxt = `PCM_STBY_RST;
      end
      // gyro that clocks the device goes to standby: back to internal oscillator
      if (pwr_nxt.timing_source_select >= `PCM_CLK_GX &&
            pwr_nxt.timing_source_select <= `PCM_CLK_GZ &&
            stby_nxt[3'h3 - pwr_nxt.timing_source_select]) begin
         pwr_nxt.timing_source_select = `PCM_CLK_INT; // [R18]
      end
      busy_nxt = (rst_cnt_nxt != 5'h00); // [R2]
   end

   // wake timer and power outputs
   always_comb begin
      us_div_nxt = us_tick ? 6'h00 : us_div_r + 6'h01;
      wake_cnt_nxt = wake_cnt_r;
      sample_nxt = 1'b0;
      if (mode != pcm_pkg::PCM_MODE_CYCLE) begin
         wake_cnt_nxt = 20'h00000;
      end else if (us_tick) begin
         if (wake_cnt_r >= wake_period - 20'h00001) begin
            wake_cnt_nxt = 20'h00000;
            sample_nxt = 1'b1; // [R4] [R13]
         end else begin
            wake_cnt_nxt = wake_cnt_r + 20'h00001;
         end
      end
      sleep_nxt = (mode != pcm_pkg::PCM_MODE_RUN); // [R3]
      a_on_nxt = 3'h0;
      g_on_nxt = 3'h0;
      temp_on_nxt = 1'b0;
      case (mode)
         pcm_pkg::PCM_MODE_RUN: begin
            a_on_nxt = ~{stby_r.accel_x_standby, stby_r.accel_y_standby,
                  stby_r.accel_z_standby}; // [R16]
            g_on_nxt = ~{stby_r.gyro_x_standby, stby_r.gyro_y_standby,
                  stby_r.gyro_z_standby}; // [R17] [R11]
            temp_on_nxt = !pwr_r.thermo_sensor_off; // [R5]
         end
         pcm_pkg::PCM_MODE_CYCLE: begin
            // only the accelerometer wakes, for one sample
            a_on_nxt = {3{sample_nxt}} & ~{stby_r.accel_x_standby,
                  stby_r.accel_y_standby, stby_r.accel_z_standby}; // [R15]
         end
         default: begin
         end
      endcase
      src_nxt = pwr_r.timing_source_select; // [R6] [R7]
      hold_nxt = (pwr_r.timing_source_select == `PCM_CLK_STOP); // [R8]
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pwr_r <= `PCM_PWR_RST; // [R9]
         stby_r <= `PCM_STBY_RST;
         rst_cnt_r <= 5'h00;
         bit_cnt_r <= 3'h0;
         data_ph_r <= 1'b0;
         rd_r <= 1'b0;
         addr_r <= 7'h00;
         shin_r <= 8'h00;
         tx_r <= 8'h00;
         sdo_r <= 1'b0;
         sdo_oe_r <= 1'b0;
         clr_r <= 3'h0;
         us_div_r <= 6'h00;
         wake_cnt_r <= 20'h00000;
         sample_r <= 1'b0;
         busy_r <= 1'b0;
         sleep_r <= 1'b0;
         temp_on_r <= 1'b0;
         hold_r <= 1'b0;
         a_on_r <= 3'h0;
         g_on_r <= 3'h0;
         src_r <= 3'h0;
      end else begin
         pwr_r <= pwr_nxt;
         stby_r <= stby_nxt;
         rst_cnt_r <= rst_cnt_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         data_ph_r <= data_ph_nxt;
         rd_r <= rd_nxt;
         addr_r <= addr_nxt;
         shin_r <= shin_nxt;
         tx_r <= tx_nxt;
         sdo_r <= sdo_nxt;
         sdo_oe_r <= sdo_oe_nxt;
         clr_r <= clr_nxt;
         us_div_r <= us_div_nxt;
         wake_cnt_r <= wake_cnt_nxt;
         sample_r <= sample_nxt;
         busy_r <= busy_nxt;
         sleep_r <= sleep_nxt;
         temp_on_r <= temp_on_nxt;
         hold_r <= hold_nxt;
         a_on_r <= a_on_nxt;
         g_on_r <= g_on_nxt;
         src_r <= src_nxt;
      end
   end

   always_comb begin
      spi_sdo = sdo_r;
      spi_sdo_oe = sdo_oe_r;
      device_reset_busy = busy_r;
      sleep_active = sleep_r;
      accel_axis_on = a_on_r;
      gyro_axis_on = g_on_r;
      thermo_sensor_on = temp_on_r;
      accel_sample = sample_r;
      clock_source = src_r;
      timing_gen_hold = hold_r;
      gyro_path_clear = clr_r[`PCM_BIT_GYRO_CLR];
      accel_path_clear = clr_r[`PCM_BIT_ACCEL_CLR];
      temp_path_clear = clr_r[`PCM_BIT_TEMP_CLR];
   end
endmodule : pcm_power_clock_manager

// ### common/pcm_defs.svh
`ifndef PCM_DEFS_SVH
`define PCM_DEFS_SVH
// register offsets
`define PCM_ADDR_PWR 7'h6B
`define PCM_ADDR_STBY 7'h6C
`define PCM_ADDR_PATH 7'h68
// reset values
`define PCM_PWR_RST 8'h00
`define PCM_STBY_RST 8'h00
// writable bits, reserved bit 4 of the power register masked
`define PCM_PWR_WMASK 8'hEF
// field positions
`define PCM_BIT_DEVRST 7
`define PCM_BIT_GYRO_CLR 2
`define PCM_BIT_ACCEL_CLR 1
`define PCM_BIT_TEMP_CLR 0
`define PCM_SPI_RD_BIT 7
// clock source codes
`define PCM_CLK_INT 3'h0
`define PCM_CLK_GX 3'h1
`define PCM_CLK_GZ 3'h3
`define PCM_CLK_RSV 3'h6
`define PCM_CLK_STOP 3'h7
// timing
`define PCM_CLK_MHZ 50
`define PCM_US_CYC (`PCM_CLK_MHZ)
`define PCM_RST_CYC 16
// wake periods in microseconds for 1.25, 5, 20 and 40 Hz
`define PCM_WAKE_US_0 800000
`define PCM_WAKE_US_1 200000
`define PCM_WAKE_US_2 50000
`define PCM_WAKE_US_3 25000
`endif

// ### common/pcm_pkg.sv
package pcm_pkg;
   typedef struct packed {
      logic dev_reset;
      logic halt;
      logic cycle_wake;
      logic rsv;
      logic thermo_sensor_off;
      logic [2:0] timing_source_select;
   } pcm_pwr_type;

   typedef struct packed {
      logic [1:0] wake_rate_select;
      logic accel_x_standby;
      logic accel_y_standby;
      logic accel_z_standby;
      logic gyro_x_standby;
      logic gyro_y_standby;
      logic gyro_z_standby;
   } pcm_stby_type;

   typedef enum logic [1:0] {
      PCM_MODE_RUN,
      PCM_MODE_SLEEP,
      PCM_MODE_CYCLE
   } pcm_mode_type;
endpackage : pcm_pkg

// ### testbench/pcm_host_model.sv
`timescale 1ns/1ns
module pcm_host_model (
   input wire logic sys_clk,
   input wire logic spi_sdo,
   input wire logic spi_sdo_oe,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdi
);
   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
   end
   // mode 3 frame of address and one data byte; sclk parks high between frames
   task automatic xfer(input logic [7:0] a, input logic [7:0] w, output logic [7:0] r);
      logic [15:0] sh;
      sh = {a, w};
      r = 8'h00;
      @(negedge sys_clk);
      spi_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         repeat (4) @(negedge sys_clk);
         spi_sclk = 1'b0;
         spi_sdi = sh[i];
         repeat (4) @(negedge sys_clk);
         spi_sclk = 1'b1;
         if (i < 8) begin
            // undriven data line shows the inverse of its last bit
            r[i] = spi_sdo_oe ? spi_sdo : ~spi_sdo;
         end
      end
      repeat (4) @(negedge sys_clk);
      spi_cs_n = 1'b1;
      // released data line must not keep its last bit
      spi_sdi = ~spi_sdi;
      repeat (8) @(negedge sys_clk);
   endtask : xfer
endmodule : pcm_host_model

// ### testbench/pcm_power_clock_manager_asserts.sv
`timescale 1ns/1ns
module pcm_power_clock_manager_asserts (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic device_reset_busy,
   input wire logic sleep_active,
   input wire logic [2:0] accel_axis_on,
   input wire logic [2:0] gyro_axis_on,
   input wire logic thermo_sensor_on,
   input wire logic accel_sample,
   input wire logic [2:0] clock_source,
   input wire logic timing_gen_hold,
   input wire logic gyro_path_clear,
   input wire logic accel_path_clear,
   input wire logic temp_path_clear
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   reset_ends_a: assert property ($rose(device_reset_busy) |-> ##[1:20] !device_reset_busy)
      else $error("device reset does not finish");
   reset_defaults_a: assert property (device_reset_busy && $past(device_reset_busy, 3)
      |-> clock_source == 3'h0 && !sleep_active) else $error("reset leaves settings");
   sleep_gates_a: assert property (sleep_active && $past(sleep_active)
      |-> gyro_axis_on == 3'h0 && !thermo_sensor_on) else $error("sensor on in sleep");
   accel_gated_a: assert property (sleep_active && $past(sleep_active) && !accel_sample
      |-> accel_axis_on == 3'h0) else $error("accel on between samples");
   sample_pulse_a: assert property (accel_sample |=> !accel_sample)
      else $error("sample pulse too long");
   hold_code_a: assert property ($stable(clock_source)
      |-> timing_gen_hold == (clock_source == 3'h7)) else $error("hold disagrees with code");
   no_reserved_a: assert property (clock_source != 3'h6)
      else $error("reserved clock code in use");
   clear_pulse_a: assert property ((gyro_path_clear || accel_path_clear || temp_path_clear)
      |=> !(gyro_path_clear || accel_path_clear || temp_path_clear)) else $error("long clear");
endmodule : pcm_power_clock_manager_asserts

bind pcm_power_clock_manager pcm_power_clock_manager_asserts u_pcm_power_clock_manager_asserts (
   .sys_clk, .reset_n, .device_reset_busy, .sleep_active, .accel_axis_on, .gyro_axis_on,
   .thermo_sensor_on, .accel_sample, .clock_source, .timing_gen_hold, .gyro_path_clear,
   .accel_path_clear, .temp_path_clear
);

// ### testbench/pcm_power_clock_manager_bench.sv
`timescale 1ns/1ns
module pcm_power_clock_manager_bench;
   logic sys_clk, reset_n, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, busy, sleep_on;
   logic thermo_on, acc_smp, hold, g_clr, a_clr, t_clr, spi_sdo_oe;
   logic [2:0] acc_on, gyr_on, clk_src, clr_or;
   logic [7:0] rd_v;
   int clr_n, err_total, total_checks;
   // wake periods of 4/3/2/1 us at 50 cycles per us
   localparam logic [15:0] WAKE_CYC [4] = '{16'h00C8, 16'h0096, 16'h0064, 16'h0032};
   pcm_host_model u_pcm_host_model (.sys_clk, .spi_sdo, .spi_sdo_oe, .spi_sclk, .spi_cs_n,
      .spi_sdi);
   pcm_power_clock_manager #(.WAKE_US_0(4), .WAKE_US_1(3), .WAKE_US_2(2), .WAKE_US_3(1))
   u_pcm_power_clock_manager (.sys_clk, .reset_n, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo,
      .spi_sdo_oe, .device_reset_busy(busy), .sleep_active(sleep_on), .accel_axis_on(acc_on),
      .gyro_axis_on(gyr_on), .thermo_sensor_on(thermo_on), .accel_sample(acc_smp),
      .clock_source(clk_src), .timing_gen_hold(hold), .gyro_path_clear(g_clr),
      .accel_path_clear(a_clr), .temp_path_clear(t_clr));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) begin
      clr_or = clr_or | {g_clr, a_clr, t_clr};
      clr_n = clr_n + int'(g_clr) + int'(a_clr) + int'(t_clr);
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_pcm_host_model.xfer(a, d, rd_v);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      u_pcm_host_model.xfer(a | 8'h80, 8'h00, rd_v);
      chk("read_data", 16'(exp), 16'(rd_v));
   endtask : rd
   task automatic period(input logic [1:0] r);
      int n;
      n = 0;
      for (int k = 0; k < 2; k++) begin
         n = 1;
         @(negedge sys_clk);
         while (acc_smp !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
         end
         if (n >= 2000) begin
            err_total++;
            final_report();
         end
      end
      chk("wake_period", WAKE_CYC[r], 16'(n));
   endtask : period
   initial begin
      reset_n = 1'b0;
      clr_or = 3'h0;
      clr_n = 0;
      repeat (20) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      rd(8'h6B, 8'h00);
      rd(8'h6C, 8'h00);
      chk("clock_source", 16'h0000, 16'(clk_src));
      $display("test defaults done");
      for (int c = 0; c < 8; c++) begin
         if (c != 6) begin
            wr(8'h6B, 8'(c));
            chk("clock_source", 16'(c), 16'(clk_src));
            chk("timing_gen_hold", 16'(c == 7), 16'(hold));
         end
      end
      wr(8'h6B, 8'h01);
      wr(8'h6B, 8'h16);
      rd(8'h6B, 8'h01);
      $display("test clock codes done");
      wr(8'h6B, 8'h08);
      chk("thermo_sensor_on", 16'h0000, 16'(thermo_on));
      for (int i = 0; i < 3; i++) begin
         wr(8'h6C, 8'h24 >> i);
         chk("accel_axis_on", 16'(3'h7 ^ (3'h4 >> i)), 16'(acc_on));
         chk("gyro_axis_on", 16'(3'h7 ^ (3'h4 >> i)), 16'(gyr_on));
         rd(8'h6C, 8'h24 >> i);
      end
      wr(8'h6C, 8'h00);
      wr(8'h6B, 8'h03);
      chk("clock_source", 16'h0003, 16'(clk_src));
      wr(8'h6C, 8'h01);
      chk("clock_source", 16'h0000, 16'(clk_src));
      rd(8'h6B, 8'h00);
      wr(8'h6C, 8'h00);
      wr(8'h6B, 8'h40);
      chk("sleep_active", 16'h0001, 16'(sleep_on));
      chk("gyro_axis_on", 16'h0000, 16'(gyr_on));
      $display("test standby and sleep done");
      wr(8'h6B, 8'h28);
      for (int r = 0; r < 4; r++) begin
         wr(8'h6C, 8'(r << 6) | 8'h07);
         period(r[1:0]);
      end
      $display("test wake rates done");
      wr(8'h6B, 8'h80);
      chk("device_reset_busy", 16'h0001, 16'(busy));
      rd(8'h6B, 8'h00);
      rd(8'h6C, 8'h00);
      clr_or = 3'h0;
      clr_n = 0;
      wr(8'h68, 8'h07);
      chk("path_clear", 16'h0007, 16'(clr_or));
      chk("path_clear_count", 16'h0003, 16'(clr_n));
      rd(8'h68, 8'h00);
      rd(8'h75, 8'h00);
      $display("test device reset done");
      final_report();
   end
endmodule : pcm_power_clock_manager_bench
